// File: logic/besp_options_regs.sv
// System-error cause status and port option registers of a two-port bridge.
// Assumes config cycles arrive already decoded as single-cycle dword accesses,
// and that all bus-side event inputs are synchronous to the PCI clock.
//
// Behaviour
// - Address parity error on either bus that drove system error sets status bit 16.
// - Posted write data parity error on target bus sets status bit 17.
// - Posted write undelivered after retry limit sets status bit 18.
// - Target abort while forwarding posted write sets status bit 19.
// - Master abort while forwarding posted write sets status bit 20.
// - Delayed write undelivered after retry limit sets status bit 21.
// - Delayed read with no data after retry limit sets status bit 22.
// - Initiator not retrying before master timeout sets status bit 23.
// - Option bits 0, 6:5 and 15:12 read zero and reset zero.
// - Bit 1 lets primary line/multiple read retries match a queued plain read.
// - Bit 2 lets primary invalidate-write retries match a queued plain write.
// - Bit 3 lets secondary line/multiple read retries match a queued plain read.
// - Bit 4 lets secondary invalidate-write retries match a queued plain write.
// - Bit 7 clear converts primary invalidate-writes; set disconnects at line boundary.
// - Bit 8 does the same for secondary invalidate-writes.
// - Bit 9 enables long bus requests for locked cycles.
// - Bit 10 (reset one) holds secondary request until buffer empty or termination.
// - Bit 11 (reset one) holds primary request until buffer empty or termination.
// - Retry timeout reported after the retry limit, default two to the 24.
// - Delayed transaction master timeout after two to the 15 clocks.
`default_nettype none

module besp_options_regs #(
  parameter logic [31:0] RETRY_LIMIT    = besp_pkg::RETRY_LIMIT_RESET,
  parameter logic [15:0] MASTER_TIMEOUT = besp_pkg::MASTER_TIMEOUT_RESET
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Configuration access
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWriteData,
  output logic [31:0]      cfgReadData,
  output logic             cfgReadValid,
  // System error reporting
  input  wire logic        serrEnable,
  input  wire logic [7:0]  eventDisable,
  input  wire logic        addrParityErr,
  input  wire logic        postedParityErr,
  input  wire logic        postedTargetAbort,
  input  wire logic        postedMasterAbort,
  output logic             systemErrorOutN,
  // Retry and timeout tracking
  input  wire logic        postedPending,
  input  wire logic        postedAttempt,
  input  wire logic        delayedWritePending,
  input  wire logic        delayedWriteAttempt,
  input  wire logic        delayedReadPending,
  input  wire logic        delayedReadAttempt,
  input  wire logic        delayedQueuedWait,
  // Retry command matching, index 0 primary, 1 secondary
  input  wire logic [3:0]  retryCmd [2],
  input  wire logic [3:0]  queuedCmd [2],
  output logic [1:0]       cmdMatch,
  // Invalidate-write forwarding
  input  wire logic [3:0]  acceptedCmd [2],
  output logic [3:0]       forwardCmd [2],
  output logic [1:0]       lineDisconnect,
  // Request control
  input  wire logic        lockCycle,
  output logic             longLockRequest,
  input  wire logic [1:0]  masterWant,
  input  wire logic [1:0]  frameSeen,
  input  wire logic [1:0]  bufferEmpty,
  input  wire logic [1:0]  targetTerm,
  output logic [1:0]       masterRequest
);

  // ----------------------------------------------------------------
  // Retry and timeout counters
  // ----------------------------------------------------------------
  logic postedExpired;
  logic dWriteExpired;
  logic dReadExpired;
  logic timeoutExpired;

  besp_attempt_counter #(.WIDTH(32)) u_posted_retry (
    .clock   (clock),
    .rst     (rst),
    .active  (postedPending),
    .tick    (postedAttempt),
    .limit   (RETRY_LIMIT),
    .expired (postedExpired)
  );

  besp_attempt_counter #(.WIDTH(32)) u_dwrite_retry (
    .clock   (clock),
    .rst     (rst),
    .active  (delayedWritePending),
    .tick    (delayedWriteAttempt),
    .limit   (RETRY_LIMIT),
    .expired (dWriteExpired)
  );

  besp_attempt_counter #(.WIDTH(32)) u_dread_retry (
    .clock   (clock),
    .rst     (rst),
    .active  (delayedReadPending),
    .tick    (delayedReadAttempt),
    .limit   (RETRY_LIMIT),
    .expired (dReadExpired)
  );

  // Wait is counted in clocks, so the tick is always on
  besp_attempt_counter #(.WIDTH(16)) u_master_timeout (
    .clock   (clock),
    .rst     (rst),
    .active  (delayedQueuedWait),
    .tick    (1'b1),
    .limit   (MASTER_TIMEOUT),
    .expired (timeoutExpired)
  );

  // ----------------------------------------------------------------
  // System error events and status
  // ----------------------------------------------------------------
  logic [7:0]  rawEvent;
  logic [7:0]  liveEvent;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic        serrN_reg;
  logic        serrN_next;
  logic [15:0] option_reg;
  logic [15:0] option_next;
  logic        statusHit;
  logic        optionHit;

  // Event vector in status-bit order
  always_comb
  begin
    rawEvent = '0;
    rawEvent[besp_pkg::EVT_ADDR_PARITY]    = addrParityErr;
    rawEvent[besp_pkg::EVT_POSTED_PARITY]  = postedParityErr;
    rawEvent[besp_pkg::EVT_POSTED_UNDELIV] = postedExpired;
    rawEvent[besp_pkg::EVT_POSTED_TABORT]  = postedTargetAbort;
    rawEvent[besp_pkg::EVT_POSTED_MABORT]  = postedMasterAbort;
    rawEvent[besp_pkg::EVT_DWRITE_UNDELIV] = dWriteExpired;
    rawEvent[besp_pkg::EVT_DREAD_NODATA]   = dReadExpired;
    rawEvent[besp_pkg::EVT_MASTER_TIMEOUT] = timeoutExpired;
  end

  // Only events that reach the error pin may leave a trace in status
  assign liveEvent = rawEvent & ~eventDisable & {8{serrEnable}};

  assign statusHit = cfgAddr == besp_pkg::SERR_STATUS_OFFSET;
  assign optionHit = cfgAddr == besp_pkg::PORT_OPTION_OFFSET;

  // Set beats a write-one clear in the same cycle so no event is lost
  always_comb
  begin
    status_next = status_reg;
    if (cfgWrite && statusHit && cfgByteEn[2])
    begin
      status_next = status_next & ~cfgWriteData[23:16];
    end
    status_next = status_next | liveEvent;
    serrN_next  = ~|liveEvent;
  end

  // Reserved option bits are masked off so they cannot be written
  always_comb
  begin
    option_next = option_reg;
    if (cfgWrite && optionHit)
    begin
      if (cfgByteEn[0])
      begin
        option_next[7:0] = cfgWriteData[7:0];
      end
      if (cfgByteEn[1])
      begin
        option_next[15:8] = cfgWriteData[15:8];
      end
    end
    option_next = option_next & besp_pkg::OPT_WRITABLE_MASK;
  end

  // Status, option and error pin registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      status_reg <= besp_pkg::STATUS_RESET;
      option_reg <= besp_pkg::OPT_RESET;
      serrN_reg  <= 1'b1;
    end
    else
    begin
      status_reg <= status_next;
      option_reg <= option_next;
      serrN_reg  <= serrN_next;
    end
  end

  assign systemErrorOutN = serrN_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  // Unmapped and out-of-scope lanes read as zero
  always_comb
  begin
    rdata_next  = '0;
    rvalid_next = cfgRead;
    if (cfgRead && statusHit)
    begin
      rdata_next[23:16] = status_reg;
    end
    else if (cfgRead && optionHit)
    begin
      rdata_next[15:0] = option_reg;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cfgReadData  = rdata_reg;
  assign cfgReadValid = rvalid_reg;

  // ----------------------------------------------------------------
  // Command aliasing and invalidate-write forwarding
  // ----------------------------------------------------------------
  logic [1:0] readAlias;
  logic [1:0] writeAlias;
  logic [1:0] mwiDisc;
  logic [1:0] match_next;
  logic [1:0] match_reg;
  logic [3:0] fwd_next [2];
  logic [3:0] fwd_reg [2];
  logic [1:0] disc_next;
  logic [1:0] disc_reg;

  assign readAlias  = {option_reg[besp_pkg::OPT_SEC_READ_ALIAS],
                       option_reg[besp_pkg::OPT_PRI_READ_ALIAS]};
  assign writeAlias = {option_reg[besp_pkg::OPT_SEC_WRITE_ALIAS],
                       option_reg[besp_pkg::OPT_PRI_WRITE_ALIAS]};
  assign mwiDisc    = {option_reg[besp_pkg::OPT_SEC_MWI_DISC],
                       option_reg[besp_pkg::OPT_PRI_MWI_DISC]};

  // Exact match always counts; aliases only widen it when enabled
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      match_next[p] = retryCmd[p] == queuedCmd[p];
      if (readAlias[p] && queuedCmd[p] == besp_pkg::PLAIN_MEMORY_READ_CMD &&
          (retryCmd[p] == besp_pkg::MEMORY_READ_LINE_CMD ||
           retryCmd[p] == besp_pkg::MEMORY_READ_MULTIPLE_CMD))
      begin
        match_next[p] = 1'b1;
      end
      if (writeAlias[p] && queuedCmd[p] == besp_pkg::PLAIN_MEMORY_WRITE_CMD &&
          retryCmd[p] == besp_pkg::MEMORY_WRITE_INVALIDATE_CMD)
      begin
        match_next[p] = 1'b1;
      end
      fwd_next[p]  = acceptedCmd[p];
      disc_next[p] = 1'b0;
      if (acceptedCmd[p] == besp_pkg::MEMORY_WRITE_INVALIDATE_CMD)
      begin
        if (mwiDisc[p])
        begin
          disc_next[p] = 1'b1;
        end
        else
        begin
          fwd_next[p] = besp_pkg::PLAIN_MEMORY_WRITE_CMD;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      match_reg <= '0;
      disc_reg  <= '0;
      fwd_reg   <= '{default: '0};
    end
    else
    begin
      match_reg <= match_next;
      disc_reg  <= disc_next;
      fwd_reg   <= fwd_next;
    end
  end

  assign cmdMatch       = match_reg;
  assign forwardCmd     = fwd_reg;
  assign lineDisconnect = disc_reg;

  // ----------------------------------------------------------------
  // Bus request control of the internal masters
  // ----------------------------------------------------------------
  besp_pkg::besp_req_state_t reqState_reg [2];
  besp_pkg::besp_req_state_t reqState_next [2];
  logic [1:0] holdReq;
  logic       longLock_reg;
  logic       longLock_next;

  assign holdReq = {option_reg[besp_pkg::OPT_SEC_HOLD_REQ],
                    option_reg[besp_pkg::OPT_PRI_HOLD_REQ]};

  // Holding trades bus fairness for fewer re-arbitrations on bursts
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      reqState_next[p] = reqState_reg[p];
      case (reqState_reg[p])
        besp_pkg::REQ_IDLE:
        begin
          if (masterWant[p])
          begin
            reqState_next[p] = besp_pkg::REQ_ACTIVE;
          end
        end
        besp_pkg::REQ_ACTIVE:
        begin
          if (holdReq[p])
          begin
            if (bufferEmpty[p] || targetTerm[p])
            begin
              reqState_next[p] = besp_pkg::REQ_IDLE;
            end
          end
          else if (frameSeen[p])
          begin
            reqState_next[p] = besp_pkg::REQ_IDLE;
          end
        end
        default:
        begin
          reqState_next[p] = besp_pkg::REQ_IDLE;
        end
      endcase
    end
    longLock_next = lockCycle & option_reg[besp_pkg::OPT_LONG_LOCK_REQ];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reqState_reg <= '{default: besp_pkg::REQ_IDLE};
      longLock_reg <= 1'b0;
    end
    else
    begin
      reqState_reg <= reqState_next;
      longLock_reg <= longLock_next;
    end
  end

  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      masterRequest[p] = reqState_reg[p] == besp_pkg::REQ_ACTIVE;
    end
  end

  assign longLockRequest = longLock_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_addr_parity_set: assert property (@(posedge clock) disable iff (rst)
    addrParityErr && serrEnable && !eventDisable[0] |=> status_reg[0] && !systemErrorOutN)
    else $error("address parity event did not set status");

  a_posted_parity_set: assert property (@(posedge clock) disable iff (rst)
    postedParityErr && serrEnable && !eventDisable[1] |=> status_reg[1])
    else $error("posted parity event did not set status");

  a_tabort_set: assert property (@(posedge clock) disable iff (rst)
    postedTargetAbort && serrEnable && !eventDisable[3] |=> status_reg[3])
    else $error("target abort event did not set status");

  a_mabort_set: assert property (@(posedge clock) disable iff (rst)
    postedMasterAbort && serrEnable && !eventDisable[4] |=> status_reg[4])
    else $error("master abort event did not set status");

  a_status_cause: assert property (@(posedge clock) disable iff (rst)
    !$stable(status_reg) && (status_reg & ~$past(status_reg)) != '0 |-> !systemErrorOutN)
    else $error("status bit rose without system error");

  a_masked_quiet: assert property (@(posedge clock) disable iff (rst)
    !serrEnable |=> systemErrorOutN)
    else $error("system error driven while disabled");

  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    cfgRead && optionHit |=> cfgReadValid && cfgReadData[15:12] == 4'h0
      && cfgReadData[6:5] == 2'b00 && !cfgReadData[0])
    else $error("reserved option bits read nonzero");

  a_w1c_clear: assert property (@(posedge clock) disable iff (rst)
    cfgWrite && statusHit && cfgByteEn[2] && cfgWriteData[16] && !liveEvent[0]
      |=> !status_reg[0])
    else $error("write one did not clear status bit");

  a_mwi_convert: assert property (@(posedge clock) disable iff (rst)
    acceptedCmd[0] == besp_pkg::MEMORY_WRITE_INVALIDATE_CMD && !mwiDisc[0]
      |=> forwardCmd[0] == besp_pkg::PLAIN_MEMORY_WRITE_CMD && !lineDisconnect[0])
    else $error("primary invalidate write not converted");

  a_read_alias: assert property (@(posedge clock) disable iff (rst)
    queuedCmd[0] == besp_pkg::PLAIN_MEMORY_READ_CMD
      && retryCmd[0] == besp_pkg::MEMORY_READ_LINE_CMD |=> cmdMatch[0] == $past(readAlias[0]))
    else $error("primary read alias mismatch");

  a_hold_release: assert property (@(posedge clock) disable iff (rst)
    masterRequest[0] && holdReq[0] && !bufferEmpty[0] && !targetTerm[0] |=> masterRequest[0])
    else $error("primary request dropped while holding");

  a_long_lock: assert property (@(posedge clock) disable iff (rst)
    lockCycle |=> longLockRequest == $past(option_reg[besp_pkg::OPT_LONG_LOCK_REQ]))
    else $error("long lock request wrong");

endmodule

`default_nettype wire

// File: common/besp_pkg.sv
// Shared constants for the bridge error-status and port-option register block.
// Assumes a 32-bit configuration access port decoded from primary-bus config cycles.
`default_nettype none

package besp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets of aligned dwords)
  // ----------------------------------------------------------------
  localparam logic [7:0]  SERR_STATUS_OFFSET  = 8'h68;
  localparam logic [7:0]  PORT_OPTION_OFFSET  = 8'h74;

  // Status field sits in byte lane 2 of its dword (bits 23:16)
  localparam int          STATUS_LSB          = 16;
  localparam int          STATUS_WIDTH        = 8;
  localparam logic [7:0]  STATUS_RESET        = 8'h00;

  // Status bit indices inside the 8-bit field
  localparam int          EVT_ADDR_PARITY     = 0;
  localparam int          EVT_POSTED_PARITY   = 1;
  localparam int          EVT_POSTED_UNDELIV  = 2;
  localparam int          EVT_POSTED_TABORT   = 3;
  localparam int          EVT_POSTED_MABORT   = 4;
  localparam int          EVT_DWRITE_UNDELIV  = 5;
  localparam int          EVT_DREAD_NODATA    = 6;
  localparam int          EVT_MASTER_TIMEOUT  = 7;

  // Port option field positions
  localparam int          OPT_PRI_READ_ALIAS  = 1;
  localparam int          OPT_PRI_WRITE_ALIAS = 2;
  localparam int          OPT_SEC_READ_ALIAS  = 3;
  localparam int          OPT_SEC_WRITE_ALIAS = 4;
  localparam int          OPT_PRI_MWI_DISC    = 7;
  localparam int          OPT_SEC_MWI_DISC    = 8;
  localparam int          OPT_LONG_LOCK_REQ   = 9;
  localparam int          OPT_SEC_HOLD_REQ    = 10;
  localparam int          OPT_PRI_HOLD_REQ    = 11;
  localparam logic [15:0] OPT_WRITABLE_MASK   = 16'h0f9e;
  localparam logic [15:0] OPT_RESET           = 16'h0c00;

  // Bus command encodings
  localparam logic [3:0]  PLAIN_MEMORY_READ_CMD       = 4'h6;
  localparam logic [3:0]  PLAIN_MEMORY_WRITE_CMD      = 4'h7;
  localparam logic [3:0]  MEMORY_READ_MULTIPLE_CMD    = 4'hc;
  localparam logic [3:0]  MEMORY_READ_LINE_CMD        = 4'he;
  localparam logic [3:0]  MEMORY_WRITE_INVALIDATE_CMD = 4'hf;

  // Attempt and clock limits (counts of PCI clocks / attempts)
  localparam logic [31:0] RETRY_LIMIT_RESET    = 32'h0100_0000;
  localparam logic [15:0] MASTER_TIMEOUT_RESET = 16'h8000;

  // Port index in two-element arrays
  localparam int          PORT_PRI            = 0;
  localparam int          PORT_SEC            = 1;

  typedef enum logic {REQ_IDLE, REQ_ACTIVE} besp_req_state_t;

endpackage

`default_nettype wire

// File: logic/besp_attempt_counter.sv
// Counts ticks while a transaction is outstanding and pulses for one cycle every time the count reaches the limit.
// Assumes active and tick come from logic on the same clock.
`default_nettype none

module besp_attempt_counter #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Counting control
  input  wire logic             active,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  // Result
  output logic                  expired
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             expired_reg;
  logic             expired_next;

  // Count restarts whenever the transaction retires; a zero limit never fires
  always_comb
  begin
    count_next   = count_reg;
    expired_next = 1'b0;
    if (!active)
    begin
      count_next = '0;
    end
    else if (tick && limit != '0)
    begin
      if (count_reg == limit - WIDTH'(1))
      begin
        expired_next = 1'b1;
        count_next   = '0;
      end
      else
      begin
        count_next = count_reg + WIDTH'(1);
      end
    end
  end

  // Register stage
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_reg   <= '0;
      expired_reg <= 1'b0;
    end
    else
    begin
      count_reg   <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;

endmodule

`default_nettype wire

// File: testbench/besp_far_side.sv
// Far-side model: initiators that keep retrying queued transactions.
// Assumes the bench holds start high for as long as a transaction stays queued.
`default_nettype none

module besp_far_side (
  // Clock
  input  wire logic       clock,
  // Control from bench, one bit per transaction kind
  input  wire logic [2:0] start,
  // Retry activity seen by the bridge
  output logic      [2:0] pending,
  output logic      [2:0] attempt
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pending follows start; a retry lands every second clock, like a slow master
  assign pending = start;

  // Attempt pulses alternate so the bridge never sees a solid level
  always_ff @(posedge clock)
  begin
    attempt <= start & ~attempt;
  end
endmodule

`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the error-status and port-option registers.
// Assumes the far-side model and the design in logic/ are compiled first.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] RD = besp_pkg::PLAIN_MEMORY_READ_CMD;
  localparam logic [3:0] WR = besp_pkg::PLAIN_MEMORY_WRITE_CMD;
  localparam logic [3:0] RM = besp_pkg::MEMORY_READ_MULTIPLE_CMD;
  localparam logic [3:0] RL = besp_pkg::MEMORY_READ_LINE_CMD;
  localparam logic [3:0] WI = besp_pkg::MEMORY_WRITE_INVALIDATE_CMD;
  typedef struct {logic [15:0] o; logic [3:0] r, q; logic [1:0] m; logic [7:0] f;
                  logic [1:0] d;} besp_row_t;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        clock, rst, cfgWrite, cfgRead, cfgReadValid, serrEnable, serrN;
  logic [7:0]  cfgAddr, eventDisable;
  logic [3:0]  cfgByteEn, errEvt;
  logic [31:0] cfgWriteData, cfgReadData;
  logic [2:0]  start, pending, attempt;
  logic        queuedWait, lockCycle, longLockRequest;
  logic [3:0]  retryCmd [2], queuedCmd [2], acceptedCmd [2], forwardCmd [2];
  logic [1:0]  cmdMatch, lineDisconnect, masterWant, frameSeen, bufferEmpty;
  logic [1:0]  targetTerm, masterRequest;
  int          n_fail, num_checks;
  int          bitOf [4] = '{0, 1, 3, 4};
  logic [7:0]  st;
  besp_row_t   rows [8] = '{
    '{16'h0000, RL, RD, 2'b00, {WR, WR}, 2'b00}, '{16'h000a, RL, RD, 2'b11, {WR, WR}, 2'b00},
    '{16'h0002, RM, RD, 2'b01, {WR, WR}, 2'b00}, '{16'h0008, RM, RD, 2'b10, {WR, WR}, 2'b00},
    '{16'h0014, WI, WR, 2'b11, {WR, WR}, 2'b00}, '{16'h0004, WI, WR, 2'b01, {WR, WR}, 2'b00},
    '{16'h0080, RD, RD, 2'b11, {WR, WI}, 2'b01}, '{16'h0100, RD, RD, 2'b11, {WI, WR}, 2'b10}};

  // Short retry and timeout counts keep the run brief
  besp_options_regs #(.RETRY_LIMIT(32'h0000_0004), .MASTER_TIMEOUT(16'h0008)) besp_options_regs_i (
    .clock(clock), .rst(rst), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
    .cfgReadValid(cfgReadValid), .serrEnable(serrEnable), .eventDisable(eventDisable),
    .addrParityErr(errEvt[0]), .postedParityErr(errEvt[1]), .postedTargetAbort(errEvt[2]),
    .postedMasterAbort(errEvt[3]), .systemErrorOutN(serrN), .postedPending(pending[0]),
    .postedAttempt(attempt[0]), .delayedWritePending(pending[1]),
    .delayedWriteAttempt(attempt[1]), .delayedReadPending(pending[2]),
    .delayedReadAttempt(attempt[2]), .delayedQueuedWait(queuedWait), .retryCmd(retryCmd),
    .queuedCmd(queuedCmd), .cmdMatch(cmdMatch), .acceptedCmd(acceptedCmd),
    .forwardCmd(forwardCmd), .lineDisconnect(lineDisconnect), .lockCycle(lockCycle),
    .longLockRequest(longLockRequest), .masterWant(masterWant), .frameSeen(frameSeen),
    .bufferEmpty(bufferEmpty), .targetTerm(targetTerm), .masterRequest(masterRequest));
  besp_far_side besp_far_side_i (.clock(clock), .start(start), .pending(pending),
    .attempt(attempt));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Config write held for exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWriteData <= d;
    @(posedge clock);
    cfgWrite <= 1'b0;
  endtask

  // Read answer stands one cycle only, so it is looked at straight after the edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    @(posedge clock);
    cfgRead <= 1'b0;
    #1 chk(cfgReadValid, 1);
    chk(cfgReadData, exp);
  endtask

  task automatic pulse(input logic [3:0] e);
    @(posedge clock);
    errEvt <= e;
    @(posedge clock);
    errEvt <= 4'h0;
  endtask

  // Request runs: want, then frame, then empty buffer or target stop
  task automatic req(input logic [15:0] o, input logic [1:0] held, input logic useTerm);
    wr(8'h74, 4'h3, {16'h0000, o});
    masterWant <= 2'b11;
    repeat (2) @(posedge clock);
    #1 chk(masterRequest, 2'b11);
    @(posedge clock);
    frameSeen <= 2'b11;
    masterWant <= 2'b00;
    @(posedge clock);
    frameSeen <= 2'b00;
    #1 chk(masterRequest, held);
    @(posedge clock);
    if (useTerm) targetTerm <= 2'b11;
    else bufferEmpty <= 2'b11;
    repeat (2) @(posedge clock);
    bufferEmpty <= 2'b00;
    targetTerm <= 2'b00;
    #1 chk(masterRequest, 2'b00);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------
  always #2.5 clock = ~clock;

  // Whole sequence needs well under a thousand clocks
  initial
  begin
    #20000;
    n_fail++;
    results();
  end

  initial
  begin
    {clock, cfgWrite, cfgRead, cfgAddr, cfgByteEn, cfgWriteData, eventDisable} = '0;
    {errEvt, start, queuedWait, lockCycle, masterWant, frameSeen, bufferEmpty} = '0;
    {serrEnable, targetTerm, rst} = 4'b1001;
    retryCmd = '{RD, RD};
    queuedCmd = '{RD, RD};
    acceptedCmd = '{WI, WI};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(8'h74, 32'h0000_0c00);
    rd(8'h68, 32'h0);
    wr(8'h74, 4'h3, 32'hffff_ffff);
    rd(8'h74, 32'h0000_0f9e);
    rd(8'h70, 32'h0);
    // Command matching and invalidate-write forwarding table
    foreach (rows[k])
    begin
      wr(8'h74, 4'h3, {16'h0000, rows[k].o});
      retryCmd <= '{rows[k].r, rows[k].r};
      queuedCmd <= '{rows[k].q, rows[k].q};
      repeat (2) @(posedge clock);
      #1 chk(cmdMatch, rows[k].m);
      chk({forwardCmd[1], forwardCmd[0]}, rows[k].f);
      chk(lineDisconnect, rows[k].d);
    end
    // Commands other than invalidate-write pass through untouched
    acceptedCmd <= '{RD, WR};
    repeat (2) @(posedge clock);
    #1 chk({forwardCmd[1], forwardCmd[0]}, {WR, RD});
    chk(lineDisconnect, 2'b00);
    // Gated events must leave pin and status alone
    serrEnable <= 1'b0;
    pulse(4'h1);
    #1 chk(serrN, 1);
    serrEnable <= 1'b1;
    eventDisable <= 8'h01;
    pulse(4'h1);
    #1 chk(serrN, 1);
    rd(8'h68, 32'h0);
    eventDisable <= 8'h00;
    st = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      pulse(4'h1 << i);
      #1 chk(serrN, 0);
      st[bitOf[i]] = 1'b1;
      rd(8'h68, {8'h00, st, 16'h0000});
    end
    // Retry limits and master timeout, counts scaled down
    for (int i = 0; i < 4; i++)
    begin
      if (i < 3) start <= 3'b001 << i;
      else queuedWait <= 1'b1;
      repeat (14) @(posedge clock);
      start <= 3'b000;
      queuedWait <= 1'b0;
      st[(i == 0) ? 2 : i + 4] = 1'b1;
      rd(8'h68, {8'h00, st, 16'h0000});
    end
    wr(8'h68, 4'hb, 32'hffff_ffff);
    rd(8'h68, 32'h00ff_0000);
    wr(8'h68, 4'h4, 32'h0055_0000);
    rd(8'h68, 32'h00aa_0000);
    req(16'h0c00, 2'b11, 1'b0);
    req(16'h0c00, 2'b11, 1'b1);
    req(16'h0000, 2'b00, 1'b0);
    req(16'h0400, 2'b10, 1'b0);
    wr(8'h74, 4'h3, 32'h0000_0200);
    lockCycle <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(longLockRequest, 1);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd(8'h74, 32'h0000_0c00);
    rd(8'h68, 32'h0);
    chk(longLockRequest, 0);
    chk(masterRequest, 2'b00);
    results();
  end
endmodule

`default_nettype wire
